// ===== hw/amlc_top.sv
// Contract
// - Automute low nibble picks shared delay: 1-5 ms, then 10-110 ms in 10 ms steps.
// - Automute high nibble sets input threshold; codes 0,1 mean bit 1, else bit n.
// - Offset high nibble moves PWM threshold 0-7 bits up, or down when top bit set.
// - Offset low nibble sets back-end reset period: under 1 ms, 1-9 ms, else 10 ms.
// - Modulation limit uses bits 2:0 only; limit k+1 ticks, min width 2(k+1).
// - Modulation limit resets to code 2; host may program any code 0-7, higher or lower.
// - Cleared disable bits turn on PWM automute and input automute detection.
// - Unmute threshold is one bit above input threshold, or equal when bit set.
// - Per channel: allow back-end reset sequence; require ok low before reset.
`timescale 1ns/100ps
`include "amlc_consts.svh"
module amlc_top #(
    parameter int NCH        = 4,
    parameter int DW         = 24,
    parameter int CW         = 24,
    parameter int MS_CYCLES  = `AMLC_MS_CYCLES
) (
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic                clk_en,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata_r,
    input  wire logic [NCH*DW-1:0]   ch_mag,
    output logic      [NCH-1:0]      automute_r,
    output logic      [CW-1:0]       delay_cycles_r,
    output amlc_pkg::amlc_bit_t      in_thresh_bit_r,
    output amlc_pkg::amlc_bit_t      pwm_thresh_bit_r,
    output amlc_pkg::amlc_bit_t      unmute_bit_r,
    output logic      [CW-1:0]       reset_period_cycles_r,
    output logic      [3:0]          limit_ticks_r,
    output logic      [4:0]          min_width_ticks_r,
    output logic                     pwm_automute_en_r,
    output logic                     input_automute_en_r,
    output logic      [NCH-1:0]      backend_recovery_enable_r,
    output logic      [NCH-1:0]      reset_requires_ok_low_r,
    output logic      [NCH-1:0]      mute_requires_ok_low_r
);
    logic [7:0]     amctl_r;
    logic [7:0]     offrst_r;
    logic [2:0]     modlim_r;
    logic [2:0]     sys_r;
    logic [2:0]     chcfg_r [NCH];

    // Channel config offsets are not contiguous, so they are matched one by one
    function automatic logic [2:0] chan_decode(input logic [7:0] a);
        case (a)
            `AMLC_OFS_CHCFG1: chan_decode = 3'h4;
            `AMLC_OFS_CHCFG2: chan_decode = 3'h5;
            `AMLC_OFS_CHCFG3: chan_decode = 3'h6;
            `AMLC_OFS_CHCFG4: chan_decode = 3'h7;
            default:          chan_decode = 3'h0;
        endcase
    endfunction

    function automatic amlc_pkg::amlc_bit_t clamp_bit(input logic [5:0] v);
        if (v[5] || v == 6'h00) begin
            clamp_bit = 5'h01;
        end else if (v > 6'(DW)) begin
            clamp_bit = 5'(DW);
        end else begin
            clamp_bit = v[4:0];
        end
    endfunction

    wire [2:0] wr_ch  = chan_decode(reg_addr);
    wire [2:0] rd_ch  = chan_decode(reg_addr);
    // A write with the enable low is dropped, not held over to the next enabled edge
    wire       wr_go  = reg_wr && clk_en;
    wire       wr_am  = wr_go && (reg_addr == `AMLC_OFS_AMCTL);
    wire       wr_off = wr_go && (reg_addr == `AMLC_OFS_OFFRST);
    wire       wr_mod = wr_go && (reg_addr == `AMLC_OFS_MODLIM);
    wire       wr_sys = wr_go && (reg_addr == `AMLC_OFS_SYSCTL2);
    wire [2:0] sys_wdata = {reg_wdata[`AMLC_SYS_PWM_AM_DIS], reg_wdata[`AMLC_SYS_IN_AM_DIS],
                            reg_wdata[`AMLC_SYS_UNMUTE_EQ]};
    wire [2:0] ch_wdata  = {reg_wdata[`AMLC_CH_RECOV_EN], reg_wdata[`AMLC_CH_RST_OK_LOW],
                            reg_wdata[`AMLC_CH_MUTE_OK_LOW]};
    wire       pwm_am_off = sys_r[2];
    wire       in_am_off  = sys_r[1];
    wire       um_equal   = sys_r[0];

    // Delay decode
    wire [3:0] dly_code = amctl_r[3:0];
    wire       dly_short  = dly_code < 4'(`AMLC_DELAY_SHORT_MS);
    wire [6:0] dly_fine   = {3'h0, dly_code} + 7'h01;
    wire [6:0] dly_steps  = {3'h0, dly_code} - 7'(`AMLC_DELAY_SHORT_MS - 1);
    wire [6:0] dly_coarse = 7'(dly_steps * 7'(`AMLC_DELAY_STEP_MS));
    wire [6:0] dly_ms     = dly_short ? dly_fine : dly_coarse;
    wire [CW-1:0] dly_cyc = CW'(dly_ms * 32'(MS_CYCLES));

    // Thresholds
    wire [3:0] thr_code = amctl_r[7:4];
    wire amlc_pkg::amlc_bit_t in_bit = (thr_code < 4'h2) ? 5'h01 : {1'b0, thr_code};
    wire [5:0] off_amt  = {3'h0, offrst_r[6:4]};
    wire [5:0] pwm_raw  = offrst_r[7] ? ({1'b0, in_bit} - off_amt)
                                      : ({1'b0, in_bit} + off_amt);
    // A wide down offset would leave the sample range, so the bit is clamped
    wire amlc_pkg::amlc_bit_t pwm_bit = clamp_bit(pwm_raw);
    // One bit higher is 6 dB up
    wire amlc_pkg::amlc_bit_t um_bit  = um_equal ? in_bit
                                                 : clamp_bit({1'b0, in_bit} + 6'h01);

    // Back-end reset period; code 0 gives half a millisecond
    wire [3:0] be_code  = offrst_r[3:0];
    wire [3:0] be_ms    = (be_code >= 4'(`AMLC_BE_MAX_MS)) ? 4'(`AMLC_BE_MAX_MS) : be_code;
    wire [CW-1:0] be_cyc = (be_code == 4'h0) ? CW'(MS_CYCLES / 2)
                                             : CW'(be_ms * 32'(MS_CYCLES));

    // Pulse limiter figures
    wire [3:0] lim_tk   = {1'b0, modlim_r} + 4'h1;
    wire [4:0] minw_tk  = {lim_tk, 1'b0};

    // Read mux; unmapped offsets read as zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `AMLC_OFS_AMCTL:   rd_mux = amctl_r;
            `AMLC_OFS_OFFRST:  rd_mux = offrst_r;
            `AMLC_OFS_MODLIM:  rd_mux = {5'h00, modlim_r};
            `AMLC_OFS_SYSCTL2: rd_mux = {1'b0, sys_r[2], sys_r[1], sys_r[0], 4'h0};
            default: begin
                if (rd_ch[2]) begin
                    rd_mux = {chcfg_r[rd_ch[1:0]], 5'h00};
                end
            end
        endcase
    end

    // Reset is taken with the enable low too, so a stopped tick can still be cleared
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            amctl_r  <= `AMLC_RST_AMCTL;
            offrst_r <= `AMLC_RST_OFFRST;
            modlim_r <= `AMLC_RST_MODLIM;
            sys_r    <= `AMLC_RST_SYS;
        end else begin
            if (wr_am) begin
                amctl_r <= reg_wdata;
            end
            if (wr_off) begin
                offrst_r <= reg_wdata;
            end
            if (wr_mod) begin
                modlim_r <= reg_wdata[2:0];
            end
            if (wr_sys) begin
                sys_r <= sys_wdata;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    chcfg_r[g] <= `AMLC_RST_CH;
                end else if (wr_go && wr_ch[2] && (wr_ch[1:0] == 2'(g))) begin
                    chcfg_r[g] <= ch_wdata;
                end
            end

            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    backend_recovery_enable_r[g] <= 1'b0;
                    reset_requires_ok_low_r[g]   <= 1'b0;
                    mute_requires_ok_low_r[g]    <= 1'b0;
                end else if (clk_en) begin
                    backend_recovery_enable_r[g] <= chcfg_r[g][2];
                    reset_requires_ok_low_r[g]   <= chcfg_r[g][1];
                    mute_requires_ok_low_r[g]    <= chcfg_r[g][0];
                end
            end

            amlc_mute_det #(
                .DW (DW),
                .CW (CW)
            ) u_det (
                .clk_sys      (clk_sys),
                .reset        (reset),
                .clk_en       (clk_en),
                .det_enable   (!in_am_off),
                .sample_mag   (ch_mag[g*DW +: DW]),
                .mute_bit     (in_bit),
                .unmute_bit   (um_bit),
                .delay_cycles (dly_cyc),
                .automute_r   (automute_r[g])
            );
        end
    endgenerate

    // Decoded values are registered so every output leaves a flip-flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata_r           <= 8'h00;
            delay_cycles_r        <= '0;
            in_thresh_bit_r       <= 5'h01;
            pwm_thresh_bit_r      <= 5'h01;
            unmute_bit_r          <= 5'h01;
            reset_period_cycles_r <= '0;
            limit_ticks_r         <= 4'h3;
            min_width_ticks_r     <= 5'h06;
            // Enables read low until the first enabled edge after reset
            pwm_automute_en_r     <= 1'b0;
            input_automute_en_r   <= 1'b0;
        end else if (clk_en) begin
            // Read and write in one cycle return the old value
            if (reg_rd) begin
                reg_rdata_r <= rd_mux;
            end
            delay_cycles_r        <= dly_cyc;
            in_thresh_bit_r       <= in_bit;
            pwm_thresh_bit_r      <= pwm_bit;
            unmute_bit_r          <= um_bit;
            reset_period_cycles_r <= be_cyc;
            limit_ticks_r         <= lim_tk;
            min_width_ticks_r     <= minw_tk;
            pwm_automute_en_r     <= !pwm_am_off;
            input_automute_en_r   <= !in_am_off;
        end
    end
endmodule // amlc_top

// ===== hw/amlc_consts.svh
`ifndef AMLC_CONSTS_SVH
`define AMLC_CONSTS_SVH

// Register offsets on the serial control port
`define AMLC_OFS_SYSCTL2      8'h04
`define AMLC_OFS_CHCFG1      8'h05
`define AMLC_OFS_CHCFG2      8'h06
`define AMLC_OFS_CHCFG3      8'h0b
`define AMLC_OFS_CHCFG4      8'h0c
`define AMLC_OFS_AMCTL       8'h14
`define AMLC_OFS_OFFRST      8'h15
`define AMLC_OFS_MODLIM      8'h16

// Field positions
`define AMLC_SYS_PWM_AM_DIS  6
`define AMLC_SYS_IN_AM_DIS   5
`define AMLC_SYS_UNMUTE_EQ   4
`define AMLC_CH_RECOV_EN     7
`define AMLC_CH_RST_OK_LOW   6
`define AMLC_CH_MUTE_OK_LOW  5

// Reset values
`define AMLC_RST_AMCTL       8'h00
`define AMLC_RST_OFFRST      8'h00
`define AMLC_RST_MODLIM      3'h2
`define AMLC_RST_SYS         3'h0
`define AMLC_RST_CH          3'h0

// Timing
`define AMLC_CLK_PERIOD_NS   10
`define AMLC_MS_NS           1000000
`define AMLC_MS_CYCLES       (`AMLC_MS_NS / `AMLC_CLK_PERIOD_NS)
`define AMLC_DELAY_SHORT_MS  5
`define AMLC_DELAY_STEP_MS   10
`define AMLC_BE_MAX_MS       10

`endif

// ===== hw/amlc_pkg.sv
package amlc_pkg;
    typedef enum logic [1:0] {
        AMLC_LIVE,
        AMLC_QUIET,
        AMLC_MUTED
    } amlc_det_e;

    typedef logic [4:0] amlc_bit_t;
endpackage

// ===== hw/amlc_mute_det.sv
`timescale 1ns/100ps
module amlc_mute_det #(
    parameter int DW = 24,
    parameter int CW = 24
) (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic               clk_en,
    input  wire logic               det_enable,
    input  wire logic [DW-1:0]      sample_mag,
    input  wire amlc_pkg::amlc_bit_t mute_bit,
    input  wire amlc_pkg::amlc_bit_t unmute_bit,
    input  wire logic [CW-1:0]      delay_cycles,
    output logic                    automute_r
);
    amlc_pkg::amlc_det_e state_r;
    amlc_pkg::amlc_det_e state_nxt;
    logic [CW-1:0]       cnt_r;
    logic [CW-1:0]       cnt_nxt;

    // Level of bit n, counting the lsb as bit 1
    function automatic logic [DW:0] bit_level(input amlc_pkg::amlc_bit_t b);
        bit_level = {{DW{1'b0}}, 1'b1} << (b - 5'h01);
    endfunction

    wire below_mute  = {1'b0, sample_mag} < bit_level(mute_bit);
    wire over_unmute = {1'b0, sample_mag} >= bit_level(unmute_bit);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            amlc_pkg::AMLC_LIVE: begin
                cnt_nxt = {{(CW-1){1'b0}}, 1'b1};
                if (det_enable && below_mute) begin
                    state_nxt = amlc_pkg::AMLC_QUIET;
                end
            end
            amlc_pkg::AMLC_QUIET: begin
                // Any sample above the threshold restarts the wait
                if (!det_enable || !below_mute) begin
                    state_nxt = amlc_pkg::AMLC_LIVE;
                end else if (cnt_r >= delay_cycles) begin
                    state_nxt = amlc_pkg::AMLC_MUTED;
                end else begin
                    cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
                end
            end
            amlc_pkg::AMLC_MUTED: begin
                if (!det_enable || over_unmute) begin
                    state_nxt = amlc_pkg::AMLC_LIVE;
                end
            end
            default: state_nxt = amlc_pkg::AMLC_LIVE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r    <= amlc_pkg::AMLC_LIVE;
            cnt_r      <= '0;
            automute_r <= 1'b0;
        end else if (clk_en) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            automute_r <= (state_nxt == amlc_pkg::AMLC_MUTED);
        end
    end
endmodule // amlc_mute_det

// ===== dv/amlc_top_checker.sv
`timescale 1ns/100ps
module amlc_top_checker #(
    parameter int NCH       = 4,
    parameter int DW        = 24,
    parameter int CW        = 24,
    parameter int MS_CYCLES = 10
) (
    input wire logic                clk_sys,
    input wire logic                reset,
    input wire logic                clk_en,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata_r,
    input wire logic [NCH*DW-1:0]   ch_mag,
    input wire logic [NCH-1:0]      automute_r,
    input wire logic [CW-1:0]       delay_cycles_r,
    input wire amlc_pkg::amlc_bit_t in_thresh_bit_r,
    input wire amlc_pkg::amlc_bit_t unmute_bit_r,
    input wire logic [CW-1:0]       reset_period_cycles_r,
    input wire logic [3:0]          limit_ticks_r,
    input wire logic [4:0]          min_width_ticks_r,
    input wire logic                pwm_automute_en_r,
    input wire logic                input_automute_en_r,
    input wire logic [NCH-1:0]      backend_recovery_enable_r,
    input wire logic [NCH-1:0]      reset_requires_ok_low_r,
    input wire logic [NCH-1:0]      mute_requires_ok_low_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    function automatic int dly(logic [3:0] c);
        return (int'(c) < 5) ? int'(c) + 1 : (int'(c) - 4) * 10;
    endfunction
    function automatic int per(logic [3:0] c);
        return (c == 4'h0) ? MS_CYCLES / 2 : ((int'(c) < 10) ? int'(c) : 10) * MS_CYCLES;
    endfunction
    // Write taken, then one more enabled edge for the decode to land
    sequence s_wr(logic [7:0] a);
        reg_wr && clk_en && reg_addr == a ##1 clk_en;
    endsequence
    a_delay_code: assert property (s_wr(8'h14) |=>
        delay_cycles_r == dly($past(reg_wdata[3:0], 2)) * MS_CYCLES)
        else $error("automute delay decode wrong");
    a_thresh_code: assert property (s_wr(8'h14) |=>
        in_thresh_bit_r == (($past(reg_wdata[7:4], 2) < 4'h2) ? 5'h01 : {1'b0, $past(reg_wdata[7:4], 2)}))
        else $error("input threshold decode wrong");
    a_period_code: assert property (s_wr(8'h15) |=> reset_period_cycles_r == per($past(reg_wdata[3:0], 2)))
        else $error("reset period decode wrong");
    a_limit_code: assert property (s_wr(8'h16) |=> limit_ticks_r == $past(reg_wdata[2:0], 2) + 4'h1)
        else $error("modulation limit decode wrong");
    a_width_pair: assert property (min_width_ticks_r == {limit_ticks_r, 1'b0})
        else $error("min width not twice the limit");
    a_enable_bits: assert property (s_wr(8'h04) |=>
        {pwm_automute_en_r, input_automute_en_r} == ~$past(reg_wdata[6:5], 2))
        else $error("automute enables wrong");
    a_unmute_step: assert property (unmute_bit_r - in_thresh_bit_r <= 5'h01)
        else $error("unmute threshold off input threshold");
    a_chan_bits: assert property (s_wr(8'h05) |=>
        {backend_recovery_enable_r[0], reset_requires_ok_low_r[0], mute_requires_ok_low_r[0]}
        == $past(reg_wdata[7:5], 2))
        else $error("channel config bits wrong");
    a_mute_release: assert property (
        automute_r[0] && clk_en && ch_mag[DW-1:0] >= (1 << (unmute_bit_r - 1)) |=> !automute_r[0])
        else $error("automute not released");
    a_mute_blocked: assert property (clk_en && !input_automute_en_r |=> automute_r == '0)
        else $error("automute active while disabled");
endmodule // amlc_top_checker
bind amlc_top amlc_top_checker #(.NCH(NCH), .DW(DW), .CW(CW), .MS_CYCLES(MS_CYCLES)) i_chk (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .ch_mag(ch_mag),
    .automute_r(automute_r), .delay_cycles_r(delay_cycles_r), .in_thresh_bit_r(in_thresh_bit_r),
    .unmute_bit_r(unmute_bit_r), .reset_period_cycles_r(reset_period_cycles_r),
    .limit_ticks_r(limit_ticks_r), .min_width_ticks_r(min_width_ticks_r),
    .pwm_automute_en_r(pwm_automute_en_r), .input_automute_en_r(input_automute_en_r),
    .backend_recovery_enable_r(backend_recovery_enable_r),
    .reset_requires_ok_low_r(reset_requires_ok_low_r), .mute_requires_ok_low_r(mute_requires_ok_low_r));

// ===== dv/amlc_host_model.sv
`timescale 1ns/100ps
module amlc_host_model (
    input  wire logic       clk_sys,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hff;
        reg_wdata = 8'hff;
    end
    // Released lines show inverted values so a stale latch cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // amlc_host_model

// ===== dv/automute_modlimit_config_tb_top.sv
`timescale 1ns/100ps
module automute_modlimit_config_tb_top;
    localparam int MS = 10;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [95:0] ch_mag = {4{24'h800000}};
    logic wr, rd;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] am, lim, bre, rro, mro;
    logic [23:0] dly, per;
    amlc_pkg::amlc_bit_t in_b, pwm_b, un_b;
    logic [4:0] min_w;
    logic pen, ien;
    int n_errors = 0;
    int n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    amlc_host_model i_host (.clk_sys(clk_sys), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
    amlc_top #(.MS_CYCLES(MS)) i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata), .ch_mag(ch_mag),
        .automute_r(am), .delay_cycles_r(dly), .in_thresh_bit_r(in_b), .pwm_thresh_bit_r(pwm_b),
        .unmute_bit_r(un_b), .reset_period_cycles_r(per), .limit_ticks_r(lim), .min_width_ticks_r(min_w),
        .pwm_automute_en_r(pen), .input_automute_en_r(ien), .backend_recovery_enable_r(bre),
        .reset_requires_ok_low_r(rro), .mute_requires_ok_low_r(mro));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        chk(lim, 3);
        chk(min_w, 6);
        chk(dly, MS);
        chk(per, MS / 2);
        i_host.rd(8'h16);
        chk(rdata, 8'h02);
        for (int c = 0; c < 16; c++) begin
            i_host.wr(8'h14, {c[3:0], c[3:0]});
            @(negedge clk_sys);
            chk(dly, (c < 5 ? c + 1 : (c - 4) * 10) * MS);
            chk(in_b, c < 2 ? 1 : c);
        end
        i_host.wr(8'h14, 8'h80);
        for (int c = 0; c < 16; c++) begin
            i_host.wr(8'h15, {c[3:0], c[3:0]});
            @(negedge clk_sys);
            chk(pwm_b, c[3] ? 8 - c[2:0] : 8 + c[2:0]);
            chk(per, c == 0 ? MS / 2 : (c < 10 ? c : 10) * MS);
        end
        // Upper bits set on purpose: they must neither decode nor read back
        for (int k = 0; k < 8; k++) begin
            i_host.wr(8'h16, {5'h1f, k[2:0]});
            @(negedge clk_sys);
            chk(lim, k + 1);
            chk(min_w, 2 * (k + 1));
            i_host.rd(8'h16);
            chk(rdata, k);
        end
        clk_en = 1'b0;
        i_host.wr(8'h16, 8'h00);
        clk_en = 1'b1;
        @(negedge clk_sys);
        chk(lim, 8);
        i_host.rd(8'h30);
        chk(rdata, 8'h00);
        i_host.wr(8'h04, 8'h70);
        @(negedge clk_sys);
        chk({pen, ien}, 0);
        chk(un_b, 8);
        i_host.wr(8'h04, 8'h00);
        @(negedge clk_sys);
        chk({pen, ien}, 3);
        chk(un_b, 9);
        i_host.wr(8'h0b, 8'he0);
        i_host.wr(8'h06, 8'h40);
        i_host.wr(8'h05, 8'h20);
        @(negedge clk_sys);
        chk({bre, rro, mro}, 12'h465);
        i_host.wr(8'h14, 8'h20);
        @(negedge clk_sys);
        ch_mag = {24'h0, 24'h2, 24'h1, 24'h0};
        repeat (10) @(negedge clk_sys);
        chk(am, 0);
        @(negedge clk_sys);
        chk(am, 4'hb);
        // Between the two thresholds the mute must hold
        ch_mag[23:0] = 24'h3;
        repeat (3) @(negedge clk_sys);
        chk(am, 4'hb);
        ch_mag[23:0] = 24'h4;
        repeat (2) @(negedge clk_sys);
        chk(am, 4'ha);
        i_host.wr(8'h04, 8'h20);
        repeat (2) @(negedge clk_sys);
        chk(am, 0);
        i_host.wr(8'h16, 8'h01);
        @(negedge clk_sys);
        chk(lim, 2);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(lim, 3);
        reset = 1'b0;
        @(negedge clk_sys);
        chk(lim, 3);
        chk({pen, ien}, 3);
        i_host.rd(8'h16);
        chk(rdata, 8'h02);
        summarize();
    end
endmodule // automute_modlimit_config_tb_top
